// ==== rbc_pkg.sv ====
/*
  Package for the receive buffer credit and link controller control block.
  Holds register offsets, field positions, reset values and carrier structs.
  Assumes a 32-bit AHB-Lite register bus, one word per register.
*/
package rbc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned NUM_CH       = 8;
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned THR_W        = 8;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_FILTER_THR   = 12'h000;
  localparam logic [11:0] OFS_FLOW_THR0    = 12'h020;
  localparam logic [11:0] OFS_FREE_BUF0    = 12'h040;
  localparam logic [11:0] OFS_CTRL         = 12'h060;
  localparam logic [11:0] OFS_STATUS       = 12'h064;

  // ****************************************
  // Control and status field positions
  // ****************************************
  localparam int unsigned CTRL_FLOW_EN_BIT   = 3;
  localparam int unsigned CTRL_IDLE_CMD_BIT  = 11;
  localparam int unsigned CTRL_OWN_BIT       = 13;
  localparam int unsigned CTRL_OFFLEN_BIT    = 14;
  localparam logic [31:0] CTRL_WR_MASK       = 32'h0000_6808;
  localparam int unsigned STAT_IDLE_BIT      = 31;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] CTRL_RST           = 32'h0000_0000;
  localparam logic [CNT_W-1:0] FREE_RST      = 16'h0000;
  localparam logic [THR_W-1:0] THR_RST       = 8'h00;

  // Frame completion report from the receive path
  typedef struct packed
  {
    logic       valid;
    logic [2:0] chan;
    logic [7:0] bufs;
  } rbc_frame_t;

  // Per-channel decisions towards the receive path
  typedef struct packed
  {
    logic [7:0] filter_low;
    logic [7:0] flow_trig;
  } rbc_decide_t;

  // Descriptor write policy towards the receive DMA
  typedef struct packed
  {
    logic offlen_block;
    logic own_value;
    logic idle_cmd;
  } rbc_dma_ctl_t;

endpackage : rbc_pkg

// ==== rbc_credit_cnt.sv ====
/*
  One channel's free buffer counter with write-to-increment.
  Assumes the write and the frame decrement are single-cycle pulses.
*/
`timescale 1ns/100ps
module rbc_credit_cnt #(
  parameter int unsigned CNT_W = 16
)(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_inc,
  input  wire logic [CNT_W-1:0] i_inc_val,
  input  wire logic             i_dec,
  input  wire logic [7:0]       i_dec_val,
  output logic      [CNT_W-1:0] o_count
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Both may hit one cycle: apply add and subtract together so no credit is lost
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (i_inc)
      cnt_nxt = cnt_nxt + i_inc_val;
    if (i_dec)
      cnt_nxt = cnt_nxt - CNT_W'(i_dec_val);
  end

  // Counter register, wraps freely in modulo arithmetic
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign o_count = cnt_r;

endmodule : rbc_credit_cnt

// ==== rbc_idle_ctl.sv ====
/*
  Idle sequencer: after an idle command, waits for the receive path to be
  quiet and then reports idle. Assumes i_busy comes from same-clock logic.
*/
`timescale 1ns/100ps
module rbc_idle_ctl (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_cmd,
  input  wire logic i_busy,
  output logic      o_idle
);

  typedef enum logic [1:0] {RBC_RUN = 2'b00, RBC_DRAIN = 2'b01, RBC_IDLE = 2'b11} rbc_idle_st_t;

  rbc_idle_st_t st_r;
  rbc_idle_st_t st_nxt;

  // Frames in flight finish first, so idle never cuts a frame short
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      RBC_RUN:   if (i_cmd) st_nxt = RBC_DRAIN;
      RBC_DRAIN: if (!i_cmd) st_nxt = RBC_RUN; else if (!i_busy) st_nxt = RBC_IDLE;
      RBC_IDLE:  if (!i_cmd) st_nxt = RBC_RUN;
      default:   st_nxt = RBC_RUN;
    endcase
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      st_r <= RBC_RUN;
    else
      st_r <= st_nxt;
  end

  assign o_idle = (st_r == RBC_IDLE);

endmodule : rbc_idle_ctl

// ==== rbc_top.sv ====
/*
  Receive buffer credit accounting and upper link controller control bits,
  with an AHB-Lite register slave. Assumes one clock, synchronous reset and
  a receive path on the same clock that reports completed frames.
*/
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module rbc_top #(
  parameter int unsigned NUM_CH = rbc_pkg::NUM_CH,
  parameter int unsigned CNT_W  = rbc_pkg::CNT_W
)(
  input  wire logic                 I_CLK_SYS,
  input  wire logic                 I_RST_N,
  // AHB-Lite slave
  input  wire logic                 i_hsel,
  input  wire logic [11:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic      [31:0]          o_hrdata,
  output logic                      o_hreadyout,
  output logic                      o_hresp,
  // Receive path
  input  wire rbc_pkg::rbc_frame_t  i_frame_done,
  input  wire logic                 i_rx_busy,
  input  wire logic                 i_full_duplex,
  output rbc_pkg::rbc_decide_t      o_decide,
  output rbc_pkg::rbc_dma_ctl_t     o_dma_ctl,
  output logic                      o_force_collision,
  output logic                      o_send_pause,
  output logic                      o_idle
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Channel index of a per-channel register address
  function automatic logic [2:0] ch_of(input logic [11:0] a);
    ch_of = a[4:2];
  endfunction : ch_of

  // True when the address falls in the eight-word bank at base
  function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
    in_bank = (a[11:5] == base[11:5]);
  endfunction : in_bank

  // Below-threshold test shared by filter and flow decisions
  function automatic logic below(input logic [CNT_W-1:0] cnt, input logic [7:0] thr);
    below = (cnt < CNT_W'(thr));
  endfunction : below

  // Word-aligned form of a bus address; byte lanes are never decoded
  function automatic logic [11:0] word_addr(input logic [11:0] a);
    word_addr = {a[11:2], 2'b00};
  endfunction : word_addr

  // ****************************************
  // Bus address phase capture
  // ****************************************
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic        rd_pend_r;
  logic        rd_pend_nxt;
  logic [11:0] addr_r;
  logic [11:0] addr_nxt;

  // Capture a valid transfer; data follows in the next cycle
  always_comb
  begin
    wr_pend_nxt = 1'b0;
    rd_pend_nxt = 1'b0;
    addr_nxt    = addr_r;
    if (i_hsel && i_hready && i_htrans[1])
    begin
      wr_pend_nxt = i_hwrite;
      rd_pend_nxt = !i_hwrite;
      addr_nxt    = word_addr(i_haddr);
    end
  end

  // Address phase registers
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 12'h000;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      addr_r    <= addr_nxt;
    end
  end

  // Zero wait states, always OKAY; hsize ignored since only words are used
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ****************************************
  // Write decode
  // ****************************************
  logic wr_ctrl;
  logic wr_filt;
  logic wr_flow;
  logic wr_free;

  // Data-phase write strobes, decoded once so that the configuration
  // registers and the counters always agree on the target word.
  // Unmapped words decode to no strobe, so such writes are dropped
  assign wr_ctrl = wr_pend_r && (addr_r == rbc_pkg::OFS_CTRL);
  assign wr_filt = wr_pend_r && (addr_r == rbc_pkg::OFS_FILTER_THR);
  assign wr_flow = wr_pend_r && in_bank(addr_r, rbc_pkg::OFS_FLOW_THR0);
  assign wr_free = wr_pend_r && in_bank(addr_r, rbc_pkg::OFS_FREE_BUF0);

  // ****************************************
  // Control, thresholds
  // ****************************************
  logic [31:0]       ctrl_r;
  logic [31:0]       ctrl_nxt;
  logic [7:0]        filt_thr_r;
  logic [7:0]        filt_thr_nxt;
  logic [7:0]        flow_thr_r   [NUM_CH];
  logic [7:0]        flow_thr_nxt [NUM_CH];

  // Register writes land in the data phase
  always_comb
  begin
    ctrl_nxt     = ctrl_r;
    filt_thr_nxt = filt_thr_r;
    flow_thr_nxt = flow_thr_r;
    if (wr_ctrl)
      ctrl_nxt = i_hwdata & rbc_pkg::CTRL_WR_MASK;
    if (wr_filt)
      filt_thr_nxt = i_hwdata[7:0];
    if (wr_flow)
      flow_thr_nxt[ch_of(addr_r)] = i_hwdata[7:0];
  end

  // Configuration registers
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      ctrl_r     <= rbc_pkg::CTRL_RST;
      filt_thr_r <= rbc_pkg::THR_RST;
      for (int i = 0; i < NUM_CH; i++)
        flow_thr_r[i] <= rbc_pkg::THR_RST;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      filt_thr_r <= filt_thr_nxt;
      flow_thr_r <= flow_thr_nxt;
    end
  end

  // ****************************************
  // Free buffer counters
  // ****************************************
  logic [CNT_W-1:0] free_cnt [NUM_CH];

  // Write adds credit, frame completion removes it; a write and a frame
  // on the same channel in one cycle are both applied, so no credit is
  // lost and software never has to avoid a busy receive path
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_cnt
    rbc_credit_cnt #(
      .CNT_W     (CNT_W)
    ) u_cnt (
      .i_clk     (I_CLK_SYS),
      .i_rst_n   (I_RST_N),
      .i_inc     (wr_free && (ch_of(addr_r) == 3'(g))),
      .i_inc_val (i_hwdata[CNT_W-1:0]),
      .i_dec     (i_frame_done.valid && (i_frame_done.chan == 3'(g))),
      .i_dec_val (i_frame_done.bufs),
      .o_count   (free_cnt[g])
    );
  end

  // ****************************************
  // Decisions
  // ****************************************
  logic [7:0] filt_r;
  logic [7:0] filt_nxt;
  logic [7:0] flow_r;
  logic [7:0] flow_nxt;

  // Threshold zero never triggers since counts are never below zero.
  // Limitation: decisions trail the count by one cycle, traded for a
  // register between the counter compare and the receive path
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      filt_nxt[i] = below(free_cnt[i], filt_thr_r);
      flow_nxt[i] = ctrl_r[rbc_pkg::CTRL_FLOW_EN_BIT]
                    && below(free_cnt[i], flow_thr_r[i]);
    end
  end

  // Registered decisions give clean data outputs
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      filt_r <= 8'h00;
      flow_r <= 8'h00;
    end
    else
    begin
      filt_r <= filt_nxt;
      flow_r <= flow_nxt;
    end
  end

  // Decisions out; duplex mode picks how a flow trigger reaches the link
  assign o_decide.filter_low = filt_r;
  assign o_decide.flow_trig  = flow_r;
  assign o_force_collision   = (|flow_r) && !i_full_duplex;
  assign o_send_pause        = (|flow_r) && i_full_duplex;

  // ****************************************
  // DMA policy and idle
  // ****************************************
  // Control bits drive the receive DMA policy directly
  assign o_dma_ctl.offlen_block = ctrl_r[rbc_pkg::CTRL_OFFLEN_BIT];
  assign o_dma_ctl.own_value    = ctrl_r[rbc_pkg::CTRL_OWN_BIT];
  assign o_dma_ctl.idle_cmd     = ctrl_r[rbc_pkg::CTRL_IDLE_CMD_BIT];

  // Idle reached only once the receive path has drained
  rbc_idle_ctl u_idle (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_cmd   (ctrl_r[rbc_pkg::CTRL_IDLE_CMD_BIT]),
    .i_busy  (i_rx_busy),
    .o_idle  (o_idle)
  );

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [11:0] rd_addr;

  // Read word taken straight from the address phase
  assign rd_addr = word_addr(i_haddr);

  // Read mux, unmapped words read zero. A read right after a write to the
  // same word returns the old value, as the write lands at its data phase end
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (rd_pend_nxt)
    begin
      if (rd_addr == rbc_pkg::OFS_CTRL)
        rdata_nxt = ctrl_r;
      else if (rd_addr == rbc_pkg::OFS_STATUS)
        rdata_nxt[rbc_pkg::STAT_IDLE_BIT] = o_idle;
      else if (rd_addr == rbc_pkg::OFS_FILTER_THR)
        rdata_nxt[7:0] = filt_thr_r;
      else if (in_bank(i_haddr, rbc_pkg::OFS_FLOW_THR0))
        rdata_nxt[7:0] = flow_thr_r[ch_of(i_haddr)];
      else if (in_bank(i_haddr, rbc_pkg::OFS_FREE_BUF0))
        rdata_nxt[CNT_W-1:0] = free_cnt[ch_of(i_haddr)];
    end
  end

  // Read data registered in the address phase, valid in the data phase;
  // zero outside a read data phase, so stale words never linger on the bus
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rdata_nxt;
  end

  assign o_hrdata = rdata_r;

endmodule : rbc_top

// ==== rbc_monitor.sv ====
/*
  Checker for rbc_top, bound to its ports.
  Assumes a zero-wait AHB-Lite slave and registered receive decisions.
*/
`timescale 1ns/100ps
module rbc_monitor (
  input wire logic                 I_CLK_SYS,
  input wire logic                 I_RST_N,
  input wire logic                 i_hsel,
  input wire logic [11:0]          i_haddr,
  input wire logic [1:0]           i_htrans,
  input wire logic                 i_hwrite,
  input wire logic                 i_hready,
  input wire logic [31:0]          o_hrdata,
  input wire logic                 i_rx_busy,
  input wire logic                 i_full_duplex,
  input wire rbc_pkg::rbc_decide_t o_decide,
  input wire rbc_pkg::rbc_dma_ctl_t o_dma_ctl,
  input wire logic                 o_force_collision,
  input wire logic                 o_send_pause,
  input wire logic                 o_idle
);
  // ****
  // Helpers
  // ****
  // Read address phase taken this cycle
  logic rd;
  assign rd = i_hsel & i_hready & i_htrans[1] & ~i_hwrite;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  // ****
  // Properties
  // ****
  // Duplex mode picks collision or pause
  property p_coll;
    o_force_collision == (|o_decide.flow_trig && !i_full_duplex);
  endproperty
  a_coll: assert property (p_coll) else $error("collision mismatch");
  property p_pause;
    o_send_pause == (|o_decide.flow_trig && i_full_duplex);
  endproperty
  a_pause: assert property (p_pause) else $error("pause mismatch");
  // Idle only after a command with a quiet receive path
  property p_idle_rise;
    $rose(o_idle) |-> $past(o_dma_ctl.idle_cmd && !i_rx_busy);
  endproperty
  a_idle_rise: assert property (p_idle_rise) else $error("idle rose early");
  property p_idle_drop;
    !o_dma_ctl.idle_cmd |=> !o_idle;
  endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("idle held");
  property p_idle_set;
    (o_dma_ctl.idle_cmd && !i_rx_busy) [*2] |=> o_idle;
  endproperty
  a_idle_set: assert property (p_idle_set) else $error("idle missing");
  property p_rst0;
    $rose(I_RST_N) |-> o_decide == '0 && o_dma_ctl == '0 && !o_idle;
  endproperty
  a_rst0: assert property (p_rst0) else $error("reset value");
  // Reserved bits read zero
  property p_ctrl_rsv;
    $past(rd) && $past(i_haddr[11:2]) == rbc_pkg::OFS_CTRL[11:2] |->
      (o_hrdata & ~rbc_pkg::CTRL_WR_MASK) == 32'h0;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("control reserved");
  property p_free_hi;
    $past(rd) && $past(i_haddr[11:5]) == 7'h02 |-> o_hrdata[31:16] == 16'h0;
  endproperty
  a_free_hi: assert property (p_free_hi) else $error("count upper");
  property p_thr_hi;
    $past(rd) && $past(i_haddr[11:5]) == 7'h01 |-> o_hrdata[31:8] == 24'h0;
  endproperty
  a_thr_hi: assert property (p_thr_hi) else $error("threshold upper");
  c_idle: cover property ($rose(o_idle));
  c_pause: cover property (o_send_pause);
  c_coll: cover property (o_force_collision);
endmodule : rbc_monitor

bind rbc_top rbc_monitor mon_u (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
  .o_hrdata(o_hrdata), .i_rx_busy(i_rx_busy), .i_full_duplex(i_full_duplex),
  .o_decide(o_decide), .o_dma_ctl(o_dma_ctl), .o_force_collision(o_force_collision),
  .o_send_pause(o_send_pause), .o_idle(o_idle));

// ==== tb_top.sv ====
/*
  Self-checking bench for rbc_top.
  Assumes a zero-wait AHB-Lite slave and one 250 MHz clock.
*/
`timescale 1ns/100ps
module tb_top;
  logic                 clk;
  logic                 rst_n;
  logic                 hsel;
  logic                 hwrite;
  logic                 busy;
  logic                 fdx;
  logic                 hresp;
  logic                 coll;
  logic                 pause;
  logic                 idle;
  wire logic            rdy;
  logic [11:0]          haddr;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic [31:0]          rd;
  rbc_pkg::rbc_frame_t  frame;
  rbc_pkg::rbc_decide_t dec;
  rbc_pkg::rbc_dma_ctl_t dma;
  int                   num_errors;
  int                   check_count;

  // Slave ready feeds the bus ready
  rbc_top dut_u (.I_CLK_SYS(clk), .I_RST_N(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(hresp),
    .i_frame_done(frame), .i_rx_busy(busy), .i_full_duplex(fdx), .o_decide(dec),
    .o_dma_ctl(dma), .o_force_collision(coll), .o_send_pause(pause), .o_idle(idle));

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One single word transfer, waiting on ready in both phases
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(hresp), 32'h0);
  endtask : rchk

  task automatic wcyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wcyc

  function automatic logic [11:0] thr_a(input int n);
    return rbc_pkg::OFS_FLOW_THR0 + 12'(4 * n);
  endfunction : thr_a

  function automatic logic [11:0] free_a(input int n);
    return rbc_pkg::OFS_FREE_BUF0 + 12'(4 * n);
  endfunction : free_a

  task automatic t_reset;
    for (int n = 0; n < 8; n++)
    begin
      rchk(thr_a(n), 32'h0);
      rchk(free_a(n), 32'h0);
    end
    rchk(rbc_pkg::OFS_CTRL, 32'h0);
    rchk(rbc_pkg::OFS_STATUS, 32'h0);
    $display("t_reset done");
  endtask : t_reset

  // Upper threshold bits must be dropped; unmapped space stays zero
  task automatic t_regs;
    for (int n = 0; n < 8; n++)
      bus(1'b1, thr_a(n), 32'hffff_ffa0 + 32'(n));
    for (int n = 0; n < 8; n++)
      rchk(thr_a(n), 32'ha0 + 32'(n));
    bus(1'b1, rbc_pkg::OFS_FILTER_THR, 32'hffff_ff07);
    rchk(rbc_pkg::OFS_FILTER_THR, 32'h07);
    bus(1'b1, 12'h100, 32'hffff_ffff);
    rchk(12'h100, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_free;
    bus(1'b1, free_a(3), 32'h5);
    bus(1'b1, free_a(3), 32'h7);
    rchk(free_a(3), 32'hc);
    bus(1'b1, free_a(3), 32'hfffe);
    rchk(free_a(3), 32'ha);
    @(posedge clk);
    frame <= '{valid: 1'b1, chan: 3'h3, bufs: 8'h04};
    @(posedge clk);
    frame <= '0;
    rchk(free_a(3), 32'h6);
    rchk(free_a(2), 32'h0);
    $display("t_free done");
  endtask : t_free

  // Channel 3 sits at 6 buffers, the others at 0
  task automatic t_decide;
    bus(1'b1, thr_a(3), 32'h6);
    bus(1'b1, rbc_pkg::OFS_CTRL, 32'h8);
    fdx <= 1'b1;
    wcyc(3);
    chk(32'(dec), 32'hfff7);
    chk(32'(pause), 32'h1);
    chk(32'(coll), 32'h0);
    fdx <= 1'b0;
    wcyc(2);
    chk(32'(coll), 32'h1);
    bus(1'b1, thr_a(3), 32'h7);
    bus(1'b1, rbc_pkg::OFS_FILTER_THR, 32'h6);
    wcyc(3);
    chk(32'(dec), 32'hf7ff);
    bus(1'b1, rbc_pkg::OFS_CTRL, 32'h0);
    bus(1'b1, rbc_pkg::OFS_FILTER_THR, 32'h0);
    wcyc(3);
    chk(32'(dec), 32'h0);
    chk(32'(coll), 32'h0);
    $display("t_decide done");
  endtask : t_decide

  // Idle must wait for a quiet receive path
  task automatic t_ctrl;
    busy <= 1'b1;
    bus(1'b1, rbc_pkg::OFS_CTRL, 32'hffff_ffff);
    rchk(rbc_pkg::OFS_CTRL, rbc_pkg::CTRL_WR_MASK);
    chk(32'(dma), 32'h7);
    wcyc(4);
    chk(32'(idle), 32'h0);
    busy <= 1'b0;
    wcyc(3);
    chk(32'(idle), 32'h1);
    rchk(rbc_pkg::OFS_STATUS, 32'h8000_0000);
    bus(1'b1, rbc_pkg::OFS_CTRL, 32'h4000);
    wcyc(2);
    chk(32'(dma), 32'h4);
    chk(32'(idle), 32'h0);
    bus(1'b1, rbc_pkg::OFS_CTRL, 32'h2000);
    wcyc(1);
    chk(32'(dma), 32'h2);
    bus(1'b1, rbc_pkg::OFS_CTRL, 32'h800);
    wcyc(1);
    chk(32'(idle), 32'h0);
    wcyc(2);
    chk(32'(idle), 32'h1);
    chk(32'(dma), 32'h1);
    $display("t_ctrl done");
  endtask : t_ctrl

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // ****
  // Processes
  // ****
  // Free-running clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Runs take a few hundred cycles, so this only trips on a hang
  initial
  begin
    wcyc(5000);
    num_errors++;
    $display("Error at %0t: timeout", $time);
    print_verdict();
  end

  initial
  begin
    num_errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 12'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    frame = '0;
    busy = 1'b0;
    fdx = 1'b0;
    wcyc(20);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_free();
    t_decide();
    t_ctrl();
    print_verdict();
  end
endmodule : tb_top
